// [rtl/flb_pkg.sv]
package flb_pkg;

	// Pointer values that select a fuse or lock byte during an armed load.
	localparam logic [15:0] FLB_Z_FUSE_LOW = 16'h0000;
	localparam logic [15:0] FLB_Z_LOCK = 16'h0001;
	localparam logic [15:0] FLB_Z_FUSE_EXT = 16'h0002;
	localparam logic [15:0] FLB_Z_FUSE_HIGH = 16'h0003;

	// Arming windows in CPU cycles, counted from the cycle after the control write.
	localparam logic [2:0] FLB_LOAD_WINDOW = 3'h3;
	localparam logic [2:0] FLB_STORE_WINDOW = 3'h4;

	// Pointer field positions.
	localparam int FLB_Z_PAGE_MSB = 13;
	localparam int FLB_Z_PAGE_LSB = 7;
	localparam int FLB_Z_WORD_MSB = 6;
	localparam int FLB_Z_WORD_LSB = 1;
	localparam int FLB_PAGE_W = 7;
	localparam int FLB_WORD_W = 6;
	localparam int FLB_PC_W = 13;

	// Lock byte layout: two unused top bits read as one (unprogrammed).
	localparam logic [1:0] FLB_LOCK_PAD = 2'h3;
	// Extended fuse byte: upper four bits undefined, read as one.
	localparam logic [3:0] FLB_EXT_PAD = 4'hf;

	// Boot section starts, by boot-size select code.
	localparam logic [12:0] FLB_BOOT_START_128 = 13'h1f80;
	localparam logic [12:0] FLB_BOOT_START_256 = 13'h1f00;
	localparam logic [12:0] FLB_BOOT_START_512 = 13'h1e00;
	localparam logic [12:0] FLB_BOOT_START_1024 = 13'h1c00;
	localparam logic [12:0] FLB_RWW_LAST = 13'h1bff;
	localparam logic [12:0] FLB_HALTING_WRITE_SECTION_FIRST = 13'h1c00;

	// Flash write time, printed in microseconds, converted to cycles at 125 MHz.
	localparam longint FLB_CLK_HZ = 125000000;
	localparam longint FLB_WRITE_MIN_US = 3700;
	localparam longint FLB_WRITE_MAX_US = 4500;
	localparam longint FLB_WRITE_MIN_CYC = (FLB_WRITE_MIN_US * FLB_CLK_HZ + 999999) / 1000000;
	localparam longint FLB_WRITE_MAX_CYC = (FLB_WRITE_MAX_US * FLB_CLK_HZ) / 1000000;
	// Nominal: midway between the two bounds.
	localparam longint FLB_WRITE_NOM_CYC = (FLB_WRITE_MIN_CYC + FLB_WRITE_MAX_CYC) / 2;
	localparam int FLB_TMR_W = 20;

	// Sequencer states.
	typedef enum logic [1:0] {
		FLB_IDLE = 2'b00,
		FLB_ARMED = 2'b01,
		FLB_WRITING = 2'b10
	} flb_state_t;

	// Flash write kinds.
	typedef enum logic [1:0] {
		FLB_OP_NONE = 2'b00,
		FLB_OP_ERASE = 2'b01,
		FLB_OP_WRITE = 2'b10,
		FLB_OP_LOCK = 2'b11
	} flb_op_t;

	// Control register write from the CPU.
	typedef struct packed {
		logic pageWriteBit;
		logic pageEraseBit;
		logic lockSetBit;
		logic rwwReenableBit;
		logic selfProgEnableBit;
	} flb_ctrl_t;

	// Fuse and lock store contents (zero means programmed).
	typedef struct packed {
		logic [7:0] fuseLowBits;
		logic [7:0] fuseHighBits;
		logic [3:0] fuseExtendedBits;
		logic [5:0] lockBits;
	} flb_fuses_t;

	// Decoded flash command going to the array.
	typedef struct packed {
		flb_op_t op;
		logic [FLB_PAGE_W-1:0] pageSelectField;
		logic [FLB_WORD_W-1:0] wordSelectField;
	} flb_cmd_t;

endpackage : flb_pkg

// [rtl/flb_boot_map.sv]
`timescale 1ns/1ns
// Decodes section membership of a word address from the boot-size fuses.
module flb_boot_map
	import flb_pkg::*;
(
	input wire logic bootSizeSelHi,
	input wire logic bootSizeSelLo,
	input wire logic [FLB_PC_W-1:0] wordAddr,
	output logic [FLB_PC_W-1:0] bootStart,
	output logic inBootSection,
	output logic inRwwSection
);

	// Boot start address from the two select fuses.
	always_comb begin
		case ({bootSizeSelHi, bootSizeSelLo})
			2'b11: bootStart = FLB_BOOT_START_128;
			2'b10: bootStart = FLB_BOOT_START_256;
			2'b01: bootStart = FLB_BOOT_START_512;
			default: bootStart = FLB_BOOT_START_1024;
		endcase
	end

	// Boot section runs up to the top of flash; the section split is fixed.
	assign inBootSection = (wordAddr >= bootStart);
	assign inRwwSection = (wordAddr <= FLB_RWW_LAST);

endmodule : flb_boot_map

// [rtl/flb_fuse_lock_seq.sv]
`timescale 1ns/1ns
// Summary of operation
// - Armed load at pointer one returns lock bits.
// - Arm bits self-clear on read or timeout.
// - Unarmed load reads program memory normally.
// - Lock byte bits five to zero ordered.
// - Pointer zero returns fuse low byte.
// - Pointer three returns fuse high byte.
// - Pointer two returns extended fuse nibble.
// - Programmed bits read zero, unprogrammed one.
// - Reset with power good does not abort a running write.
// - Flash writes last between 3.7 and 4.5 ms.
// - Boot fuses select boot section size.
// - Fixed read-while-write and halting section split.
// - Page select comes from pointer bits 13:7.
// - Pointer bits 6:1 pick buffer word.
// - Pointer bits 15:14 ignored except by armed fuse loads; bit zero byte-selects loads.
// - Busy flag holds until re-enable after programming.
module flb_fuse_lock_seq
	import flb_pkg::*;
#(
	parameter longint WRITE_CYCLES = FLB_WRITE_NOM_CYC
)(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic powerGood,
	input wire logic ctrlWrite,
	input wire flb_ctrl_t ctrlData,
	input wire logic loadStrobe,
	input wire logic storeStrobe,
	input wire logic [15:0] zPointer,
	input wire logic [15:0] progMemWord,
	input wire flb_fuses_t fuseStore,
	input wire logic eepromWriteBusyBit,
	output logic [7:0] loadData,
	output logic loadDone,
	output logic selfProgEnableBit,
	output logic lockSetBit,
	output logic rwwBusyFlag,
	output logic flashBusy,
	output flb_cmd_t flashCmd,
	output logic flashCmdValid,
	output logic [FLB_PC_W-1:0] bootStart,
	output logic zInBootSection,
	output logic zInRwwSection
);

	// Sequencer state, arming window counter and write timer.
	flb_state_t state_q, state_d;
	logic [2:0] win_q, win_d;
	logic lockSet_q, lockSet_d;
	logic self_prog_enable_bit_q, self_prog_enable_bit_d;
	logic [2:0] armCmd_q, armCmd_d; // Erase, write, re-enable bits latched at arming.
	logic [FLB_TMR_W-1:0] tmr_q, tmr_d;
	logic rwwBusy_q, rwwBusy_d;
	flb_cmd_t cmd_q, cmd_d;
	logic cmdValid_q, cmdValid_d;
	logic [7:0] data_q, data_d;
	logic done_q, done_d;
	// Pending write that must survive a reset; a powered reset cannot abort it.
	logic pendWrite_q;
	logic [FLB_TMR_W-1:0] pendTmr_q;
	logic resume_q; // Set while reset is held, cleared on the first edge after it.
	logic [12:0] zWordAddr; // Word address from the pointer.
	logic [7:0] fuseByte; // Selected fuse or lock byte.
	logic [7:0] progByte; // Ordinary program memory byte.
	logic armedRead; // Both arm bits set, read window open.
	logic writeEnd; // Write timer reaches its end this cycle.

	localparam logic [FLB_TMR_W-1:0] WriteCycles = FLB_TMR_W'(WRITE_CYCLES);

	// Word address ignores the two top pointer bits and the byte bit.
	assign zWordAddr = zPointer[FLB_Z_PAGE_MSB:FLB_Z_WORD_LSB];

	// Section decode of the current pointer.
	flb_boot_map u_map (
		.bootSizeSelHi(fuseStore.fuseHighBits[2]),
		.bootSizeSelLo(fuseStore.fuseHighBits[1]),
		.wordAddr(zWordAddr),
		.bootStart(bootStart),
		.inBootSection(zInBootSection),
		.inRwwSection(zInRwwSection)
	);

	// Byte select of an ordinary load: bit zero picks the high byte.
	assign progByte = zPointer[0] ? progMemWord[15:8] : progMemWord[7:0];

	// Fuse and lock byte selection; stored bits are raw, zero means programmed.
	always_comb begin
		case (zPointer[1:0])
			FLB_Z_FUSE_LOW[1:0]: fuseByte = fuseStore.fuseLowBits;
			FLB_Z_LOCK[1:0]: fuseByte = {FLB_LOCK_PAD, fuseStore.lockBits};
			FLB_Z_FUSE_EXT[1:0]: fuseByte = {FLB_EXT_PAD, fuseStore.fuseExtendedBits};
			FLB_Z_FUSE_HIGH[1:0]: fuseByte = fuseStore.fuseHighBits;
			default: fuseByte = fuseStore.fuseLowBits;
		endcase
	end

	assign armedRead = (state_q == FLB_ARMED) && lockSet_q && self_prog_enable_bit_q
		&& (win_q < FLB_LOAD_WINDOW);
	assign writeEnd = (tmr_q == FLB_TMR_W'(1));

	// Next-state logic for arming, reading and flash write timing.
	always_comb begin
		state_d = state_q;
		win_d = win_q;
		lockSet_d = lockSet_q;
		self_prog_enable_bit_d = self_prog_enable_bit_q;
		armCmd_d = armCmd_q;
		tmr_d = tmr_q;
		rwwBusy_d = rwwBusy_q;
		cmd_d = cmd_q;
		cmdValid_d = 1'b0;
		data_d = data_q;
		done_d = 1'b0;
		// Every load answers one cycle later, except a load on the edge that resumes a write after reset.
		if (loadStrobe) begin
			done_d = 1'b1;
			data_d = (armedRead && (zPointer[15:2] == FLB_Z_FUSE_LOW[15:2]))
				? fuseByte : progByte;
		end
		case (state_q)
			FLB_IDLE: begin
				// Control writes are refused while the EEPROM is writing.
				if (ctrlWrite && ctrlData.selfProgEnableBit && !eepromWriteBusyBit) begin
					state_d = FLB_ARMED;
					win_d = 3'h0;
					self_prog_enable_bit_d = 1'b1;
					lockSet_d = ctrlData.lockSetBit;
					armCmd_d = {ctrlData.pageEraseBit, ctrlData.pageWriteBit,
						ctrlData.rwwReenableBit};
				end
			end
			FLB_ARMED: begin
				win_d = win_q + 3'h1;
				if (lockSet_q && loadStrobe && armedRead) begin
					state_d = FLB_IDLE;
					lockSet_d = 1'b0;
					self_prog_enable_bit_d = 1'b0;
				end else if (storeStrobe && (win_q < FLB_STORE_WINDOW)) begin
					cmd_d.pageSelectField = zPointer[FLB_Z_PAGE_MSB:FLB_Z_PAGE_LSB];
					cmd_d.wordSelectField = zPointer[FLB_Z_WORD_MSB:FLB_Z_WORD_LSB];
					if (lockSet_q) begin
						cmd_d.op = FLB_OP_LOCK;
					end else if (armCmd_q[2]) begin
						cmd_d.op = FLB_OP_ERASE;
					end else if (armCmd_q[1]) begin
						cmd_d.op = FLB_OP_WRITE;
					end else begin
						cmd_d.op = FLB_OP_NONE; // Buffer fill or re-enable.
					end
					cmdValid_d = 1'b1;
					lockSet_d = 1'b0;
					if (lockSet_q || armCmd_q[2] || armCmd_q[1]) begin
						state_d = FLB_WRITING;
						tmr_d = WriteCycles;
						if (!lockSet_q && zWordAddr <= FLB_RWW_LAST) begin
							rwwBusy_d = 1'b1;
						end
					end else begin
						state_d = FLB_IDLE;
						self_prog_enable_bit_d = 1'b0;
						if (armCmd_q[0]) begin
							rwwBusy_d = 1'b0;
						end
					end
				end else if ((lockSet_q && win_q >= FLB_LOAD_WINDOW - 3'h1)
					|| (win_q >= FLB_STORE_WINDOW - 3'h1)) begin
					state_d = FLB_IDLE;
					lockSet_d = 1'b0;
					self_prog_enable_bit_d = 1'b0;
				end
			end
			FLB_WRITING: begin
				tmr_d = tmr_q - FLB_TMR_W'(1);
				if (writeEnd) begin
					state_d = FLB_IDLE;
					self_prog_enable_bit_d = 1'b0;
				end
			end
			default: begin
				state_d = FLB_IDLE;
			end
		endcase
	end

	// Sequencer registers; a running write is resumed after a reset with power good.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= FLB_IDLE;
			win_q <= 3'h0;
			lockSet_q <= 1'b0;
			self_prog_enable_bit_q <= 1'b0;
			armCmd_q <= 3'h0;
			tmr_q <= '0;
			rwwBusy_q <= 1'b0;
			cmd_q <= '0;
			cmdValid_q <= 1'b0;
			data_q <= 8'h00;
			done_q <= 1'b0;
		end else if (pendWrite_q && resume_q) begin
			// First cycle after a reset that hit a write: carry on timing it.
			state_q <= FLB_WRITING;
			tmr_q <= pendTmr_q;
			self_prog_enable_bit_q <= 1'b1;
			rwwBusy_q <= 1'b1;
		end else begin
			state_q <= state_d;
			win_q <= win_d;
			lockSet_q <= lockSet_d;
			self_prog_enable_bit_q <= self_prog_enable_bit_d;
			armCmd_q <= armCmd_d;
			tmr_q <= tmr_d;
			rwwBusy_q <= rwwBusy_d;
			cmd_q <= cmd_d;
			cmdValid_q <= cmdValid_d;
			data_q <= data_d;
			done_q <= done_d;
		end
	end

	// Shadow of the write state, not cleared by reset, so that a write completes.
	// It tracks the next state while running and freezes while reset is held;
	// a supply that is not good drops the pending write.
	always_ff @(posedge clk_sys) begin
		if (!arst_n) begin
			pendWrite_q <= pendWrite_q && powerGood;
			pendTmr_q <= pendTmr_q;
			resume_q <= 1'b1;
		end else begin
			pendWrite_q <= (state_d == FLB_WRITING) && powerGood;
			pendTmr_q <= tmr_d;
			resume_q <= 1'b0;
		end
	end

	assign loadData = data_q;
	assign loadDone = done_q;
	assign selfProgEnableBit = self_prog_enable_bit_q;
	assign lockSetBit = lockSet_q;
	assign rwwBusyFlag = rwwBusy_q;
	assign flashBusy = (state_q == FLB_WRITING);
	assign flashCmd = cmd_q;
	assign flashCmdValid = cmdValid_q;

endmodule : flb_fuse_lock_seq

// [sim/flb_fuse_lock_seq_chk.sv]
`timescale 1ns/1ns
// Watches readback, arming windows, commands and the boot map.
module flb_fuse_lock_seq_chk
	import flb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic loadStrobe,
	input wire logic storeStrobe,
	input wire logic [15:0] zPointer,
	input wire logic [15:0] progMemWord,
	input wire flb_fuses_t fuseStore,
	input wire logic [7:0] loadData,
	input wire logic selfProgEnableBit,
	input wire logic lockSetBit,
	input wire logic rwwBusyFlag,
	input wire logic flashBusy,
	input wire flb_cmd_t flashCmd,
	input wire logic flashCmdValid,
	input wire logic [FLB_PC_W-1:0] bootStart,
	input wire logic zInRwwSection
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// An armed readback load aimed at a fuse or lock place.
	wire logic rd = lockSetBit && selfProgEnableBit && loadStrobe && zPointer[15:2] == 14'h0;
	a_lock_byte: assert property (
		rd && zPointer[1:0] == 2'h1 |=> loadData == {2'h3, $past(fuseStore.lockBits)})
		else $error("lock byte wrong");
	a_fuse_low: assert property (
		rd && zPointer[1:0] == 2'h0 |=> loadData == $past(fuseStore.fuseLowBits))
		else $error("low fuse byte wrong");
	a_arm_timeout: assert property (
		$rose(lockSetBit) ##0 !loadStrobe [*3] |=> !lockSetBit)
		else $error("read arm outlived window");
	a_store_timeout: assert property (
		$rose(selfProgEnableBit) && !lockSetBit && !flashBusy ##0 !storeStrobe [*4]
		|=> !selfProgEnableBit)
		else $error("store arm outlived window");
	a_plain_load: assert property (
		loadStrobe && !selfProgEnableBit |=> loadData == ($past(zPointer[0]) ?
		$past(progMemWord[15:8]) : $past(progMemWord[7:0])))
		else $error("plain load wrong");
	a_busy_hold: assert property (
		$fell(rwwBusyFlag) |-> !flashBusy && $past(storeStrobe))
		else $error("busy flag fell early");
	a_page_field: assert property (
		flashCmdValid |-> flashCmd.pageSelectField == $past(zPointer[13:7])
		&& flashCmd.wordSelectField == $past(zPointer[6:1]))
		else $error("page or word field wrong");
	a_boot_start: assert property (
		bootStart == 13'(14'h2000 - (14'h80 << (2'h3 - fuseStore.fuseHighBits[2:1]))))
		else $error("boot start wrong");
	a_rww_split: assert property (
		zInRwwSection == (zPointer[13:1] <= FLB_RWW_LAST))
		else $error("section split wrong");
	c_lock_read: cover property (rd && zPointer[1:0] == 2'h1);
	c_write_end: cover property ($fell(flashBusy));
	c_rww_back: cover property ($fell(rwwBusyFlag));
endmodule : flb_fuse_lock_seq_chk
bind flb_fuse_lock_seq flb_fuse_lock_seq_chk flb_fuse_lock_seq_chk_inst (.*);

// [sim/flb_cpu_model.sv]
`timescale 1ns/1ns
// CPU stand-in: a control write, then a load or store some cycles later.
module flb_cpu_model
	import flb_pkg::*;
(
	input wire logic clk_sys,
	output logic ctrlWrite,
	output flb_ctrl_t ctrlData,
	output logic loadStrobe,
	output logic storeStrobe,
	output logic [15:0] zPointer,
	output logic [15:0] progMemWord
);
	// Program memory holds a fixed pattern of the word address.
	assign progMemWord = {zPointer[8:1] ^ 8'h5a, zPointer[8:1]};
	// Idle levels from time zero.
	initial begin
		ctrlWrite = 1'b0;
		ctrlData = 5'h00;
		loadStrobe = 1'b0;
		storeStrobe = 1'b0;
		zPointer = 16'h0000;
	end
	// One access; a gap of zero means no control write before it.
	task automatic op(input flb_ctrl_t c, input logic [15:0] z, input logic ld,
		input logic st, input int gap);
		@(negedge clk_sys);
		ctrlWrite = gap > 0;
		ctrlData = c;
		zPointer = z;
		repeat (gap) begin
			@(negedge clk_sys);
			ctrlWrite = 1'b0;
			ctrlData = ~c;
		end
		loadStrobe = ld;
		storeStrobe = st;
		@(negedge clk_sys);
		loadStrobe = 1'b0;
		storeStrobe = 1'b0;
	endtask : op
endmodule : flb_cpu_model

// [sim/tb_fuse_lock_readback_boot_map.sv]
`timescale 1ns/1ns
// Self-checking bench for the fuse and lock readback sequencer.
module tb_fuse_lock_readback_boot_map;
	import flb_pkg::*;
	localparam longint W = 20;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic powerGood = 1'b0;
	logic eepromWriteBusyBit = 1'b0;
	flb_fuses_t fuseStore = {8'h62, 8'h99, 4'h5, 6'h2c};
	logic ctrlWrite, loadStrobe, storeStrobe, loadDone, selfProgEnableBit, lockSetBit;
	logic rwwBusyFlag, flashBusy, flashCmdValid, zInBootSection, zInRwwSection;
	flb_ctrl_t ctrlData;
	flb_cmd_t flashCmd;
	logic [15:0] zPointer, progMemWord;
	logic [7:0] loadData;
	logic [12:0] bootStart;
	int badCount = 0;
	int nTests = 0;
	// The clock toggles every half period of 4 ns.
	always #4 clk_sys = ~clk_sys;
	flb_cpu_model flb_cpu_model_inst (.clk_sys(clk_sys), .ctrlWrite(ctrlWrite),
		.ctrlData(ctrlData), .loadStrobe(loadStrobe), .storeStrobe(storeStrobe),
		.zPointer(zPointer), .progMemWord(progMemWord));
	flb_fuse_lock_seq #(.WRITE_CYCLES(W)) flb_fuse_lock_seq_inst (.clk_sys(clk_sys),
		.arst_n(arst_n), .powerGood(powerGood), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData),
		.loadStrobe(loadStrobe), .storeStrobe(storeStrobe), .zPointer(zPointer),
		.progMemWord(progMemWord), .fuseStore(fuseStore),
		.eepromWriteBusyBit(eepromWriteBusyBit), .loadData(loadData), .loadDone(loadDone),
		.selfProgEnableBit(selfProgEnableBit), .lockSetBit(lockSetBit),
		.rwwBusyFlag(rwwBusyFlag), .flashBusy(flashBusy), .flashCmd(flashCmd),
		.flashCmdValid(flashCmdValid), .bootStart(bootStart),
		.zInBootSection(zInBootSection), .zInRwwSection(zInRwwSection));
	// Prints the counts and the verdict, then stops.
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : giveVerdict
	// Compares one value; an unknown bit matches only an unknown bit.
	task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chkv
	// Waits, bounded, until the last command ended and no EEPROM write runs.
	task automatic waitIdle(output int i);
		for (i = 0; i < 200 && (selfProgEnableBit !== 1'b0 || eepromWriteBusyBit); i++)
			@(negedge clk_sys);
		if (i == 200) begin
			badCount++;
			giveVerdict();
		end
	endtask : waitIdle
	// Re-enables the section until its busy flag reads clear.
	task automatic backToRww();
		int n;
		for (int j = 0; j < 3 && rwwBusyFlag !== 1'b0; j++) begin
			waitIdle(n);
			flb_cpu_model_inst.op(5'h03, 16'h0000, 1'b0, 1'b1, 1);
		end
		chkv(16'(rwwBusyFlag), 16'h0000);
	endtask : backToRww
	// Expected byte of an ordinary load.
	function automatic logic [7:0] pm(input logic [15:0] z);
		return z[0] ? z[8:1] ^ 8'h5a : z[8:1];
	endfunction : pm
	// Main sequence.
	initial begin
		logic [7:0] fx [4];
		logic [12:0] bs [4];
		int n;
		fx = '{8'h62, {2'h3, 6'h2c}, {4'hf, 4'h5}, 8'h99};
		bs = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
		repeat (20) @(negedge clk_sys);
		arst_n = 1'b1;
		powerGood = 1'b1;
		flb_cpu_model_inst.op(5'h00, 16'hc345, 1'b1, 1'b0, 0);
		chkv(16'(loadData), 16'(pm(16'hc345)));
		flb_cpu_model_inst.op(5'h00, 16'h0344, 1'b1, 1'b0, 0);
		chkv(16'(loadData), 16'(pm(16'h0344)));
		$display("test plain loads done");
		for (int k = 0; k < 4; k++) begin
			flb_cpu_model_inst.op(5'h05, 16'(k), 1'b1, 1'b0, 1 + k % 3);
			chkv({7'h0, loadDone, fx[k]}, {8'h01, fx[k]});
			chkv(16'({lockSetBit, selfProgEnableBit}), 16'h0000);
		end
		flb_cpu_model_inst.op(5'h05, 16'h0001, 1'b1, 1'b0, 4);
		chkv(16'(loadData), 16'(pm(16'h0001)));
		eepromWriteBusyBit = 1'b1;
		flb_cpu_model_inst.op(5'h05, 16'h0000, 1'b1, 1'b0, 1);
		chkv(16'(loadData), 16'(pm(16'h0000)));
		eepromWriteBusyBit = 1'b0;
		$display("test readback done");
		flb_cpu_model_inst.op(5'h09, 16'h0080, 1'b0, 1'b1, 5);
		chkv(16'({flashBusy, selfProgEnableBit}), 16'h0000);
		flb_cpu_model_inst.op(5'h09, 16'h4d40, 1'b0, 1'b1, 4);
		chkv({1'b0, flashCmd}, {1'b0, FLB_OP_ERASE, 7'h1a, 6'h20});
		chkv(16'({flashBusy, rwwBusyFlag, flashCmdValid}), 16'h0007);
		waitIdle(n);
		chkv(16'(n >= W - 1 && n <= W + 1), 16'h0001);
		chkv(16'(rwwBusyFlag), 16'h0001);
		backToRww();
		$display("test erase done");
		flb_cpu_model_inst.op(5'h11, 16'h0080, 1'b0, 1'b1, 1);
		repeat (5) @(negedge clk_sys);
		arst_n = 1'b0;
		@(negedge clk_sys);
		arst_n = 1'b1;
		@(negedge clk_sys);
		chkv(16'({flashBusy, rwwBusyFlag}), 16'h0003);
		waitIdle(n);
		backToRww();
		$display("test reset in write done");
		for (int s = 0; s < 4; s++) begin
			fuseStore.fuseHighBits[2:1] = 2'(s);
			flb_cpu_model_inst.op(5'h00, {2'h0, bs[s], 1'b0}, 1'b0, 1'b0, 0);
			chkv({2'h0, zInBootSection, bootStart}, {3'h1, bs[s]});
			flb_cpu_model_inst.op(5'h00, {2'h0, bs[s] - 13'h1, 1'b0}, 1'b0, 1'b0, 0);
			chkv(16'({zInBootSection, zInRwwSection}), 16'(s == 0));
		end
		$display("test boot map done");
		giveVerdict();
	end
endmodule : tb_fuse_lock_readback_boot_map
